// >>> rtl/mode_state_machine.v
/*
 operating-mode state machine: six modes, development mode, strap capture,
 watchdog failure and overvoltage reactions.
 assumes spi words arrive decoded as one-cycle strobes on core_clk_in,
 pins arrive unsynchronised, and rst_in stands for the power-on reset.
*/
// Contract
// - restart leaves for normal after reset delay once the failure is gone
// - fail-safe keeps main regulator off until wake or overtemperature ends
// - stop keeps main regulator on; sleep turns it off
// - development mode reaches all states and halts the watchdog
// - development mode only if strap pin grounded during init
// - configuration and diagnosis travel over a 16-bit spi
// - mode field set by spi writes, cleared through restart
// - start in init after power-on with a long open window
// - weak pull-down on interrupt pin throughout reset delay; the code pulls down only while power-on flag set
// - filter interrupt pin during delay, latch at reset output rise
// - while power-on flag set, each reset low phase re-samples config
// - no stable level latches config pin as zero
// - config pin one sends watchdog failure to restart
// - config pin zero sends failure to fail-safe, first with bit zero restarts
// - fail outputs after first failure if bit one, else after second
// - overvoltage with enable sets flag, fail outputs, restart or fail-safe
// - overvoltage without enable only sets flag
// - failure-count bit and config pin bit readable
// - latched configuration persists until power-on reset
// - any spi command in init moves to normal
// - host triggers watchdog inside long window, configuring it
// - no trigger in long window flags failure and enters restart
// - wake events ignored in init
// - wake in normal raises interrupt, mode unchanged
// - sleep with wake flags pending goes through restart to normal
// - stop to sleep request sets spi error and restarts
`default_nettype none
`include "mode_fsm_defines.vh"

module mode_state_machine #(
   parameter integer RESET_DELAY_CYC = `RESET_DELAY_CYC,
   parameter integer LONG_WINDOW_CYC = `LONG_WINDOW_CYC
) (
   input  wire       core_clk_in,
   input  wire       rst_in,
   input  wire       spi_cmd_in,
   input  wire       spi_mode_wr_in,
   input  wire [1:0] spi_mode_req_in,
   input  wire       wd_trigger_in,
   input  wire       fail_count_bit_in,
   input  wire       ov_reset_enable_in,
   input  wire       por_flag_clear_in,
   input  wire       test_pin_in,
   input  wire       int_pin_in,
   input  wire       overvoltage_in,
   input  wire       undervoltage_in,
   input  wire       overtemp_in,
   input  wire       wake_event_in,
   input  wire       wake_flags_pending_in,
   output reg  [2:0] mode_field_out,
   output reg        main_regulator_on_out,
   output reg        reset_output_out,
   output reg        int_pulldown_out,
   output reg        int_request_out,
   output reg        fail_outputs_out,
   output reg        overvoltage_flag_out,
   output reg        spi_error_flag_out,
   output reg        wd_failure_flag_out,
   output reg        por_flag_out,
   output reg        dev_mode_out,
   output reg        latched_config_pin_out,
   output reg        hardware_control_reg_out
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   reg [1:0] test_sync;
   reg [1:0] int_sync;
   reg [1:0] ov_sync;
   reg [1:0] uv_sync;
   reg [1:0] ot_sync;
   reg [1:0] wake_sync;

   always @(posedge core_clk_in) begin
      if (rst_in) begin
         test_sync <= 2'h3;
         int_sync  <= 2'h0;
         ov_sync   <= 2'h0;
         uv_sync   <= 2'h0;
         ot_sync   <= 2'h0;
         wake_sync <= 2'h0;
      end else begin
         test_sync <= {test_sync[0], test_pin_in};
         int_sync  <= {int_sync[0], int_pin_in};
         ov_sync   <= {ov_sync[0], overvoltage_in};
         uv_sync   <= {uv_sync[0], undervoltage_in};
         ot_sync   <= {ot_sync[0], overtemp_in};
         wake_sync <= {wake_sync[0], wake_event_in};
      end
   end

   wire test_low = ~test_sync[1];
   wire int_lvl  = int_sync[1];
   wire ov_lvl   = ov_sync[1];
   wire uv_lvl   = uv_sync[1];
   wire ot_lvl   = ot_sync[1];
   wire wake_lvl = wake_sync[1];

   ////////////////////////////////////////////////////////////////////////////
   // strap filter
   wire filt_stable;
   wire filt_level;
   reg  cfg_sampling;

   cfg_pin_filter u_filter (
      .core_clk_in  (core_clk_in),
      .rst_in       (rst_in),
      .enable_in    (cfg_sampling),
      .pin_level_in (int_lvl),
      .stable_out   (filt_stable),
      .level_out    (filt_level)
   );

   ////////////////////////////////////////////////////////////////////////////
   // state and counters
   reg [2:0]  mode;
   reg [2:0]  next_mode;
   reg [31:0] delay_cnt;
   reg [31:0] wd_cnt;
   reg        wd_long;
   reg        fail_count;
   reg        ov_last;
   reg        sleep_wait;
   reg        ot_last;

   wire delay_done = (delay_cnt >= RESET_DELAY_CYC - 1);
   wire wd_expired = wd_long && !dev_mode_out && (wd_cnt >= LONG_WINDOW_CYC - 1);
   wire ov_rise    = ov_lvl && !ov_last;
   wire ov_act     = ov_rise && ov_reset_enable_in;
   wire [2:0] fail_mode = latched_config_pin_out ? `MODE_RESTART : `MODE_FAILSAFE;
   wire enter_rst  = (next_mode == `MODE_RESTART) && (mode != `MODE_RESTART);
   wire next_ro    = enter_rst ? 1'b0 :
                     ((mode == `MODE_INIT || mode == `MODE_RESTART) && delay_done) ? 1'b1 :
                     reset_output_out;

   // destination of a watchdog failure from the config and failure count
   function [2:0] wd_fail_dest;
      input latched_config_pin;
      input cfg_bit;
      input first_done;
      begin
         if (latched_config_pin)
            wd_fail_dest = `MODE_RESTART;
         else if (!cfg_bit && !first_done)
            wd_fail_dest = `MODE_RESTART;
         else
            wd_fail_dest = `MODE_FAILSAFE;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // next mode
   always @* begin
      next_mode = mode;
      case (mode)
         `MODE_INIT: begin
            if (wd_expired)
               next_mode = `MODE_RESTART;
            else if (ov_act)
               next_mode = fail_mode;
            else if (spi_cmd_in)
               next_mode = `MODE_NORMAL;
         end
         `MODE_NORMAL, `MODE_STOP: begin
            if (wd_expired)
               next_mode = wd_fail_dest(latched_config_pin_out, fail_count_bit_in,
                                        fail_count);
            else if (ov_act)
               next_mode = fail_mode;
            else if (uv_lvl)
               next_mode = `MODE_RESTART;
            else if (spi_mode_wr_in) begin
               case (spi_mode_req_in)
                  `REQ_NORMAL: next_mode = `MODE_NORMAL;
                  `REQ_STOP:   next_mode = `MODE_STOP;
                  `REQ_SLEEP: begin
                     if (mode == `MODE_STOP)
                        next_mode = `MODE_RESTART;
                     else if (wake_flags_pending_in)
                        next_mode = `MODE_RESTART;
                     else
                        next_mode = `MODE_SLEEP;
                  end
                  default:     next_mode = mode;
               endcase
            end
         end
         `MODE_SLEEP: begin
            if (wake_lvl)
               next_mode = `MODE_RESTART;
         end
         `MODE_RESTART: begin
            if (delay_done && !uv_lvl && !ov_act)
               next_mode = `MODE_NORMAL;
         end
         `MODE_FAILSAFE: begin
            if (wake_lvl || (ot_last && !ot_lvl))
               next_mode = `MODE_RESTART;
         end
         default: next_mode = `MODE_INIT;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // mode register, timers, flags
   always @(posedge core_clk_in) begin
      if (rst_in) begin
         mode                 <= `MODE_INIT;
         mode_field_out       <= `MODE_INIT;
         delay_cnt            <= 32'h0000_0000;
         wd_cnt               <= 32'h0000_0000;
         wd_long              <= 1'b1;
         fail_count           <= 1'b0;
         ov_last              <= 1'b0;
         ot_last              <= 1'b0;
         sleep_wait           <= 1'b0;
         reset_output_out     <= 1'b0;
         fail_outputs_out     <= 1'b0;
         overvoltage_flag_out <= 1'b0;
         spi_error_flag_out   <= 1'b0;
         wd_failure_flag_out  <= 1'b0;
         int_request_out      <= 1'b0;
      end else begin
         mode           <= next_mode;
         mode_field_out <= (next_mode == `MODE_RESTART) ? `MODE_INIT : next_mode;
         ov_last        <= ov_lvl;
         ot_last        <= ot_lvl;
         sleep_wait     <= 1'b0;
         int_request_out <= (mode == `MODE_NORMAL || mode == `MODE_STOP) && wake_lvl;
         if (ov_rise)
            overvoltage_flag_out <= 1'b1;
         if (ov_act)
            fail_outputs_out <= 1'b1;
         if (spi_mode_wr_in && mode == `MODE_STOP && spi_mode_req_in == `REQ_SLEEP)
            spi_error_flag_out <= 1'b1;
         // reset output low in restart until the delay runs out
         if (next_mode == `MODE_RESTART && mode != `MODE_RESTART) begin
            delay_cnt        <= 32'h0000_0000;
            reset_output_out <= 1'b0;
         end else if (mode == `MODE_INIT || mode == `MODE_RESTART) begin
            if (delay_done)
               reset_output_out <= 1'b1;
            else
               delay_cnt <= delay_cnt + 32'h0000_0001;
         end
         // watchdog: long window in init, halted in development mode
         if (dev_mode_out) begin
            wd_cnt <= wd_cnt;
         end else if (wd_trigger_in) begin
            wd_cnt  <= 32'h0000_0000;
            wd_long <= 1'b0;
         end else if (wd_expired) begin
            wd_cnt              <= 32'h0000_0000;
            wd_long             <= 1'b1;
            wd_failure_flag_out <= 1'b1;
            fail_count          <= 1'b1;
            if (fail_count_bit_in || fail_count)
               fail_outputs_out <= 1'b1;
         end else if (wd_long && reset_output_out && mode != `MODE_SLEEP &&
                      mode != `MODE_FAILSAFE) begin
            wd_cnt <= wd_cnt + 32'h0000_0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // regulator, strap capture and development mode
   reg ro_last;

   always @(posedge core_clk_in) begin
      if (rst_in) begin
         main_regulator_on_out    <= 1'b1;
         int_pulldown_out         <= 1'b1;
         cfg_sampling             <= 1'b0;
         ro_last                  <= 1'b0;
         por_flag_out             <= 1'b1;
         dev_mode_out             <= 1'b0;
         latched_config_pin_out   <= 1'b0;
         hardware_control_reg_out <= `RST_FAIL_COUNT_BIT;
      end else begin
         main_regulator_on_out <= (next_mode != `MODE_SLEEP) &&
                                  (next_mode != `MODE_FAILSAFE);
         ro_last                  <= reset_output_out;
         hardware_control_reg_out <= fail_count_bit_in;
         if (por_flag_clear_in)
            por_flag_out <= 1'b0;
         cfg_sampling     <= por_flag_out && !reset_output_out;
         int_pulldown_out <= por_flag_out && !next_ro;
         if (por_flag_out && reset_output_out && !ro_last)
            latched_config_pin_out <= filt_stable ? filt_level : 1'b0;
         if (mode == `MODE_INIT && test_low)
            dev_mode_out <= 1'b1;
      end
   end

endmodule // mode_state_machine
`default_nettype wire

// >>> include/mode_fsm_defines.vh
/*
 operating-mode constants: mode field codes, timing figures and derived counts.
 assumes a 250 MHz core clock; included by the mode state machine files.
*/
`ifndef MODE_FSM_DEFINES_VH
`define MODE_FSM_DEFINES_VH

// mode field encoding
`define MODE_INIT      3'h0
`define MODE_NORMAL    3'h1
`define MODE_STOP      3'h2
`define MODE_SLEEP     3'h3
`define MODE_RESTART   3'h4
`define MODE_FAILSAFE  3'h5

// mode request codes carried by an spi write
`define REQ_NORMAL     2'h0
`define REQ_STOP       2'h1
`define REQ_SLEEP      2'h2

// clock and timing figures
`define CLK_MHZ            250
`define RESET_DELAY_US     10
`define RESET_DELAY_CYC    (`RESET_DELAY_US * `CLK_MHZ)
`define CFG_FILTER_US      1
`define CFG_FILTER_CYC     (`CFG_FILTER_US * `CLK_MHZ)
`define LONG_WINDOW_MS     200
`define LONG_WINDOW_CYC    (`LONG_WINDOW_MS * 1000 * `CLK_MHZ)

// reset values
`define RST_FAIL_COUNT_BIT 1'b0

`endif

// >>> rtl/cfg_pin_filter.v
/*
 continuous filter of the interrupt pin level during the reset delay.
 assumes pin_level_in is already synchronised to core_clk_in.
*/
`default_nettype none
`include "mode_fsm_defines.vh"

module cfg_pin_filter #(
   parameter integer FILTER_CYC = `CFG_FILTER_CYC
) (
   input  wire core_clk_in,
   input  wire rst_in,
   input  wire enable_in,
   input  wire pin_level_in,
   output reg  stable_out,
   output reg  level_out
);

   reg        last;
   reg [15:0] count;

   ////////////////////////////////////////////////////////////////////////////
   // a level counts only once it has held for the filter time
   always @(posedge core_clk_in) begin
      if (rst_in || !enable_in) begin
         last       <= 1'b0;
         count      <= 16'h0000;
         stable_out <= 1'b0;
         level_out  <= 1'b0;
      end else if (pin_level_in != last) begin
         last       <= pin_level_in;
         count      <= 16'h0000;
         stable_out <= 1'b0;
      end else if (count >= FILTER_CYC[15:0] - 16'h0001) begin
         stable_out <= 1'b1;
         level_out  <= last;
      end else begin
         count <= count + 16'h0001;
      end
   end

endmodule // cfg_pin_filter
`default_nettype wire

// >>> testbench/mode_fsm_monitor.sv
/*
 concurrent checks on the mode state machine ports.
 assumes it is bound to mode_state_machine, single clock domain.
*/
`default_nettype none
module mode_fsm_monitor (
   input wire logic       core_clk_in,
   input wire logic       rst_in,
   input wire logic       spi_cmd_in,
   input wire logic       spi_mode_wr_in,
   input wire logic [1:0] spi_mode_req_in,
   input wire logic       ov_reset_enable_in,
   input wire logic       overvoltage_in,
   input wire logic [2:0] mode_field_out,
   input wire logic       main_regulator_on_out,
   input wire logic       reset_output_out,
   input wire logic       int_pulldown_out,
   input wire logic       fail_outputs_out,
   input wire logic       overvoltage_flag_out,
   input wire logic       spi_error_flag_out,
   input wire logic       por_flag_out,
   input wire logic       dev_mode_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   sequence quiet_ov_rise;
      $rose(overvoltage_in) && !ov_reset_enable_in && mode_field_out == 3'h1;
   endsequence
   sequence stop_to_sleep;
      mode_field_out == 3'h2 && spi_mode_wr_in && spi_mode_req_in == 2'h2;
   endsequence
   init_to_normal_a: assert property (mode_field_out == 3'h0 && reset_output_out && spi_cmd_in
      |=> mode_field_out == 3'h1) else $error("init did not move to normal");
   stop_reg_on_a: assert property (mode_field_out == 3'h2 && $past(mode_field_out) == 3'h2
      |-> main_regulator_on_out) else $error("regulator off in stop");
   sleep_reg_off_a: assert property (mode_field_out == 3'h3 && $past(mode_field_out) == 3'h3
      |-> !main_regulator_on_out) else $error("regulator on in sleep");
   failsafe_reg_off_a: assert property (mode_field_out == 3'h5
      && $past(mode_field_out) == 3'h5 |-> !main_regulator_on_out) else $error("regulator on");
   ov_flag_set_a: assert property ($rose(overvoltage_in) |-> ##[1:6] overvoltage_flag_out)
      else $error("overvoltage flag not set");
   ov_quiet_a: assert property (quiet_ov_rise |=>
      (mode_field_out == 3'h1 && $stable(fail_outputs_out))[*6]) else $error("ov acted");
   stop_sleep_err_a: assert property (stop_to_sleep |=>
      spi_error_flag_out && mode_field_out == 3'h0) else $error("stop to sleep accepted");
   delay_pulldown_a: assert property (!reset_output_out && por_flag_out
      && main_regulator_on_out |-> int_pulldown_out) else $error("pull-down off in delay");
   ro_rise_release_a: assert property ($rose(reset_output_out) |=> ##1 !int_pulldown_out)
      else $error("pull-down kept after reset output rise");
   dev_only_init_a: assert property ($rose(dev_mode_out) |-> mode_field_out == 3'h0)
      else $error("development entered outside init");
endmodule // mode_fsm_monitor
bind mode_state_machine mode_fsm_monitor mode_fsm_monitor_i (
   .core_clk_in(core_clk_in), .rst_in(rst_in), .spi_cmd_in(spi_cmd_in),
   .spi_mode_wr_in(spi_mode_wr_in), .spi_mode_req_in(spi_mode_req_in),
   .ov_reset_enable_in(ov_reset_enable_in), .overvoltage_in(overvoltage_in),
   .mode_field_out(mode_field_out), .main_regulator_on_out(main_regulator_on_out),
   .reset_output_out(reset_output_out), .int_pulldown_out(int_pulldown_out),
   .fail_outputs_out(fail_outputs_out), .overvoltage_flag_out(overvoltage_flag_out),
   .spi_error_flag_out(spi_error_flag_out), .por_flag_out(por_flag_out),
   .dev_mode_out(dev_mode_out));
`default_nettype wire

// >>> testbench/host_model.sv
/*
 host microcontroller model: decoded spi words and watchdog service.
 assumes spi words reach the block as one-cycle strobes.
*/
`default_nettype none
module host_model (
   input  wire logic       core_clk_in,
   input  wire logic       reset_output_in,
   input  wire logic       service_in,
   output var  logic       spi_cmd_out,
   output var  logic       spi_mode_wr_out,
   output var  logic [1:0] spi_mode_req_out,
   output var  logic       wd_trigger_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int gap = 0;
   initial spi_cmd_out = 1'b0;
   initial spi_mode_wr_out = 1'b0;
   initial spi_mode_req_out = 2'h3;
   initial wd_trigger_out = 1'b0;
   // service well inside the long window, only while out of reset
   always @(posedge core_clk_in) begin
      gap <= (gap == 60) ? 0 : gap + 1;
      wd_trigger_out <= service_in && reset_output_in && gap == 60;
   end
   // one decoded 16-bit word, optionally a mode write
   task automatic spi_word(input logic wr, input logic [1:0] req);
      spi_cmd_out <= 1'b1;
      spi_mode_wr_out <= wr;
      spi_mode_req_out <= req;
      @(posedge core_clk_in);
      spi_cmd_out <= 1'b0;
      spi_mode_wr_out <= 1'b0;
      spi_mode_req_out <= ~req;
   endtask
endmodule // host_model
`default_nettype wire

// >>> testbench/tb.sv
/*
 self-checking bench for the mode state machine.
 assumes shortened reset delay and long window parameters.
*/
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic       int_pin = 1'b1;
   logic       wake = 1'b0;
   logic       ov = 1'b0;
   logic       ov_en = 1'b0;
   logic       service = 1'b0;
   logic       zero = 1'b0;
   logic       test_pin = 1'b1;
   logic       cfg_bit = 1'b0;
   logic       por_clr = 1'b0;
   logic       cmd, wr, trig, ro, reg_on, pd, irq, fo, ovf, serr, wdf, por, dev, latched_config_pin, hwc;
   logic [1:0] req;
   logic [2:0] mode;
   int         failures = 0;
   int         samples_checked = 0;
   always #2 clk = ~clk;
   mode_state_machine #(.RESET_DELAY_CYC(300), .LONG_WINDOW_CYC(200)) mode_state_machine_i (
      .core_clk_in(clk), .rst_in(rst), .spi_cmd_in(cmd), .spi_mode_wr_in(wr),
      .spi_mode_req_in(req), .wd_trigger_in(trig), .fail_count_bit_in(cfg_bit),
      .ov_reset_enable_in(ov_en), .por_flag_clear_in(por_clr), .test_pin_in(test_pin),
      .int_pin_in(int_pin), .overvoltage_in(ov), .undervoltage_in(zero), .overtemp_in(zero),
      .wake_event_in(wake), .wake_flags_pending_in(zero), .mode_field_out(mode),
      .main_regulator_on_out(reg_on), .reset_output_out(ro), .int_pulldown_out(pd),
      .int_request_out(irq), .fail_outputs_out(fo), .overvoltage_flag_out(ovf),
      .spi_error_flag_out(serr), .wd_failure_flag_out(wdf), .por_flag_out(por),
      .dev_mode_out(dev), .latched_config_pin_out(latched_config_pin), .hardware_control_reg_out(hwc));
   host_model host_model_i (.core_clk_in(clk), .reset_output_in(ro), .service_in(service),
      .spi_cmd_out(cmd), .spi_mode_wr_out(wr), .spi_mode_req_out(req), .wd_trigger_out(trig));
   task automatic check(input string what, input logic [2:0] exp, input logic [2:0] got);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic ticks(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wait_ro;
      int k;
      k = 0;
      while (ro !== 1'b1 && k < 1000) begin
         @(posedge clk);
         k++;
      end
      check("reset output rise", 3'h1, {2'h0, ro});
      ticks(3);
   endtask
   task automatic conclude;
      if (failures == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      #200000;
      failures++;
      conclude();
   end
   ////////////////////////////////////////////////////////////////////////////////////
   initial begin
      ticks(2);
      rst <= 1'b0;
      ticks(3);
      check("mode", 3'h0, mode);
      check("pull-down", 3'h1, {2'h0, pd});
      wait_ro();
      check("config pin", 3'h1, {2'h0, latched_config_pin});
      check("pull-down", 3'h0, {2'h0, pd});
      check("dev mode", 3'h0, {2'h0, dev});
      check("count bit", 3'h0, {2'h0, hwc});
      for (int k = 0; k < 400 && wdf !== 1'b1; k++) ticks(1);
      check("wd failure", 3'h1, {2'h0, wdf});
      check("fail outputs", 3'h0, {2'h0, fo});
      service <= 1'b1;
      ticks(3);
      check("mode", 3'h0, mode);
      wait_ro();
      check("mode", 3'h1, mode);
      wake <= 1'b1;
      ticks(6);
      wake <= 1'b0;
      check("int request", 3'h1, {2'h0, irq});
      check("mode", 3'h1, mode);
      host_model_i.spi_word(1'b1, 2'h1);
      ticks(2);
      check("mode", 3'h2, mode);
      check("regulator", 3'h1, {2'h0, reg_on});
      host_model_i.spi_word(1'b1, 2'h2);
      ticks(2);
      check("spi error", 3'h1, {2'h0, serr});
      check("mode", 3'h0, mode);
      wait_ro();
      check("mode", 3'h1, mode);
      host_model_i.spi_word(1'b1, 2'h2);
      ticks(3);
      check("mode", 3'h3, mode);
      check("regulator", 3'h0, {2'h0, reg_on});
      wake <= 1'b1;
      ticks(6);
      wake <= 1'b0;
      wait_ro();
      check("mode", 3'h1, mode);
      ov <= 1'b1;
      ticks(8);
      ov <= 1'b0;
      check("ov flag", 3'h1, {2'h0, ovf});
      check("fail outputs", 3'h0, {2'h0, fo});
      check("mode", 3'h1, mode);
      ov_en <= 1'b1;
      ticks(4);
      ov <= 1'b1;
      ticks(6);
      check("fail outputs", 3'h1, {2'h0, fo});
      check("mode", 3'h0, mode);
      ov <= 1'b0;
      rst <= 1'b1;
      ticks(2);
      rst <= 1'b0;
      fork
         wait_ro();
         repeat (2) begin
            ticks(100);
            int_pin <= ~int_pin;
         end
      join
      check("config pin", 3'h0, {2'h0, latched_config_pin});
      host_model_i.spi_word(1'b0, 2'h3);
      ticks(1);
      check("mode", 3'h1, mode);
      ov <= 1'b1;
      for (int k = 0; k < 10 && mode !== 3'h5; k++) ticks(1);
      check("mode", 3'h5, mode);
      ticks(3);
      check("regulator", 3'h0, {2'h0, reg_on});
      check("mode", 3'h5, mode);
      wake <= 1'b1;
      ticks(6);
      wake <= 1'b0;
      wait_ro();
      check("mode", 3'h1, mode);
      rst <= 1'b1;
      ov <= 1'b0;
      service <= 1'b0;
      test_pin <= 1'b0;
      ticks(2);
      rst <= 1'b0;
      wait_ro();
      check("dev mode", 3'h1, {2'h0, dev});
      ticks(250);
      check("wd failure", 3'h0, {2'h0, wdf});
      check("mode", 3'h0, mode);
      por_clr <= 1'b1;
      ticks(1);
      por_clr <= 1'b0;
      int_pin <= 1'b0;
      host_model_i.spi_word(1'b0, 2'h3);
      ticks(1);
      host_model_i.spi_word(1'b1, 2'h1);
      ticks(1);
      host_model_i.spi_word(1'b1, 2'h2);
      ticks(3);
      check("pull-down", 3'h0, {2'h0, pd});
      wait_ro();
      check("config pin", 3'h1, {2'h0, latched_config_pin});
      rst <= 1'b1;
      test_pin <= 1'b1;
      cfg_bit <= 1'b1;
      ticks(2);
      rst <= 1'b0;
      wait_ro();
      for (int k = 0; k < 400 && wdf !== 1'b1; k++) ticks(1);
      check("fail outputs", 3'h1, {2'h0, fo});
      check("count bit", 3'h1, {2'h0, hwc});
      for (int k = 0; k < 600 && mode !== 3'h5; k++) ticks(1);
      check("mode", 3'h5, mode);
      conclude();
   end
endmodule // tb
`default_nettype wire
